// *** tcrc_map.vh ***
// constants for the type-c role configuration block
// assumes a 125 MHz system clock and register access by offset over a plain write/read port
// What this block does
// - decode three-level role strap: high source, low sink, floating dual-role.
// - sample strap once after reset, keep role until next reset.
// - with strap floating, software may force source-only via role-select field.
// - source-only role presents Rp on both CC lines continuously.
// - source role starts advertising default current level.
// - raise advertised current on strap or register request; pick matching Rp.
// - sink Rd seen while attached as source drives open-drain ID low.
// - sink plus Ra sensed switches VCONN onto the unused CC line.
// - orientation from CC lines drives the superspeed mux select.
// - orientation also shown on a dedicated direction output.
// - mux has two channels, each a 2:1 selection between pair sets.
// - mux paths settle within 0.5 us of an orientation change.
// - source features only as source; sink features only as sink.
// - no power delivery messaging on CC lines.
// - sink-only role presents Rd on both CC lines continuously.
// - dual-role alternates Rp on both lines and Rd on both lines.
`ifndef TCRC_MAP_VH
`define TCRC_MAP_VH
`define TCRC_REG_PORT_ROLE 8'h0A
`define TCRC_BIT_TERM_DIS 0
`define TCRC_FLD_ROLE_HI 5
`define TCRC_FLD_ROLE_LO 4
`define TCRC_PORT_ROLE_RST 8'h00
`define TCRC_ROLE_DRP 2'b00
`define TCRC_ROLE_SNK 2'b01
`define TCRC_ROLE_SRC 2'b10
`define TCRC_STRAP_LOW 2'b00
`define TCRC_STRAP_HIGH 2'b01
`define TCRC_CUR_DEF 2'b00
`define TCRC_CUR_MID 2'b01
`define TCRC_CUR_HIGH 2'b10
`define TCRC_CLK_MHZ 125
`define TCRC_SW_TIME_NS 500
`define TCRC_SW_CYCLES ((`TCRC_SW_TIME_NS * `TCRC_CLK_MHZ) / 1000)
`define TCRC_TOGGLE_CYCLES 32'd6250000
`endif

// *** tcrc_role_chk.sv ***
// port checker for the role controller, bound into every instance
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tcrc_role_chk #(parameter TOGGLE_CYCLES = 16) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [1:0] rp_en_o,
  input wire logic [1:0] rd_en_o,
  input wire logic [1:0] vconn_en_o,
  input wire logic id_o,
  input wire logic id_oe_o,
  input wire logic dir_oe_o,
  input wire logic mux_sel_o,
  input wire logic [1:0] mux_path_en_o,
  input wire logic attached_src_o,
  input wire logic attached_snk_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  chk_id_open_drain: assert property (id_o == 1'b0)
    else $error("id pin driven high");
  chk_id_on_attach: assert property ($rose(attached_src_o) |-> ##[0:1] id_oe_o)
    else $error("id not pulled low on attach");
  chk_vconn_spare_line: assert property (vconn_en_o != 2'h0 |->
    attached_src_o && vconn_en_o == (mux_sel_o ? 2'h1 : 2'h2)) else $error("vconn misplaced");
  chk_dir_follows_mux: assert property (attached_src_o && $past(attached_src_o) |->
    dir_oe_o == !mux_sel_o) else $error("dir and mux disagree");
  chk_mux_settle: assert property ($changed(mux_sel_o) |-> ##[1:63]
    (mux_path_en_o == 2'h3 || !(attached_src_o || attached_snk_o))) else $error("mux slow");
  chk_path_pair: assert property (mux_path_en_o == 2'h0 || mux_path_en_o == 2'h3)
    else $error("channels split");
  chk_term_exclusive: assert property ((rp_en_o & rd_en_o) == 2'h0)
    else $error("rp and rd together");
  chk_sink_quiet: assert property (attached_snk_o |-> vconn_en_o == 2'h0 && !id_oe_o)
    else $error("source feature as sink");
  cover property ($rose(attached_src_o));
  cover property (vconn_en_o != 2'h0);
  cover property ($changed(mux_sel_o));
endmodule
bind tcrc_role_ctrl tcrc_role_chk #(.TOGGLE_CYCLES(TOGGLE_CYCLES)) tcrc_role_chk_i (.clock_i,
  .rst_b_i, .rp_en_o, .rd_en_o, .vconn_en_o, .id_o, .id_oe_o, .dir_oe_o, .mux_sel_o,
  .mux_path_en_o, .attached_src_o, .attached_snk_o);
`default_nettype wire

// *** tcrc_role_ctrl.v ***
// type-c configuration channel role control with source behaviour and ss mux select
// assumes cc comparator results arrive as synchronous levels and register writes are one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "tcrc_map.vh"
module tcrc_role_ctrl #(
  parameter TOGGLE_CYCLES = `TCRC_TOGGLE_CYCLES
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire [1:0] role_strap_i,
  input wire strap_float_i,
  input wire [1:0] current_strap_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [1:0] reg_cur_sel_i,
  output reg [7:0] reg_rdata_o,
  input wire cc1_rd_i,
  input wire cc2_rd_i,
  input wire cc1_ra_i,
  input wire cc2_ra_i,
  input wire cc1_rp_i,
  input wire cc2_rp_i,
  output reg [1:0] rp_en_o,
  output reg [1:0] rd_en_o,
  output reg [1:0] rp_level_o,
  output reg [1:0] vconn_en_o,
  output wire id_o,
  output reg id_oe_o,
  output wire dir_o,
  output reg dir_oe_o,
  output reg mux_sel_o,
  output reg [1:0] mux_path_en_o,
  output reg attached_src_o,
  output reg attached_snk_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_UNATT = 2'd1;
  localparam ST_ATT_SRC = 2'd2;
  localparam ST_ATT_SNK = 2'd3;
  localparam SW_CYC = `TCRC_SW_CYCLES;
  localparam [7:0] SW_CYC8 = SW_CYC[7:0];
  localparam [1:0] PATHS_OFF = 2'b00;
  localparam [1:0] PATHS_ON = 2'b11;
  localparam [1:0] VCONN_CC1 = 2'b01;
  localparam [1:0] VCONN_CC2 = 2'b10;
  localparam [7:0] RD_UNMAPPED = 8'h00;
  reg [1:0] strap_role_reg;
  reg strap_done_reg;
  reg [7:0] port_role_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] cur_sel_reg;
  reg present_src_reg;
  reg [31:0] tog_cnt_reg;
  reg orient_reg;
  reg [7:0] sw_cnt_reg;
  wire term_dis;
  wire [1:0] role;
  wire rd1;
  wire rd2;
  wire sink_seen;
  wire src_seen;
  wire acting_src;
  wire [1:0] strap_cur;
  wire [1:0] req_cur;
  assign term_dis = port_role_reg[`TCRC_BIT_TERM_DIS];
  // strap decides unless floating; then the role field can force source
  assign role = (strap_role_reg != `TCRC_ROLE_DRP) ? strap_role_reg :
                port_role_reg[`TCRC_FLD_ROLE_HI:`TCRC_FLD_ROLE_LO];
  assign rd1 = cc1_rd_i;
  assign rd2 = cc2_rd_i;
  assign sink_seen = rd1 | rd2;
  assign src_seen = cc1_rp_i | cc2_rp_i;
  assign acting_src = (role == `TCRC_ROLE_SRC) ||
                      ((role == `TCRC_ROLE_DRP) && present_src_reg);
  assign strap_cur = current_strap_i;
  // the higher of the strap and software requests wins
  assign req_cur = (cur_sel_reg > strap_cur) ? cur_sel_reg : strap_cur;
  // one capture after release; strap must stay static afterwards
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_role_reg <= `TCRC_ROLE_DRP;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      if (strap_float_i)
        strap_role_reg <= `TCRC_ROLE_DRP;
      else if (role_strap_i == `TCRC_STRAP_HIGH)
        strap_role_reg <= `TCRC_ROLE_SRC;
      else
        strap_role_reg <= `TCRC_ROLE_SNK;
    end
  end
  // register port; the host sequence of disable, role, enable is honoured as plain writes
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_role_reg <= `TCRC_PORT_ROLE_RST;
      cur_sel_reg <= `TCRC_CUR_DEF;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == `TCRC_REG_PORT_ROLE)
        port_role_reg <= reg_wdata_i;
      // the current request rides on every write strobe; hold it steady around role writes
      if (reg_wr_i)
        cur_sel_reg <= reg_cur_sel_i;
      if (reg_rd_i)
        reg_rdata_o <= (reg_addr_i == `TCRC_REG_PORT_ROLE) ? port_role_reg : RD_UNMAPPED;
    end
  end
  // dual-role toggle timer
  // timer runs only while unattached, so an attach freezes the presented role
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tog_cnt_reg <= 32'h0000_0000;
      present_src_reg <= 1'b1;
    end else if (state_reg == ST_UNATT && role == `TCRC_ROLE_DRP) begin
      if (tog_cnt_reg >= TOGGLE_CYCLES - 1) begin
        tog_cnt_reg <= 32'h0000_0000;
        present_src_reg <= ~present_src_reg;
      end else begin
        tog_cnt_reg <= tog_cnt_reg + 32'h0000_0001;
      end
    end else if (state_reg == ST_IDLE) begin
      tog_cnt_reg <= 32'h0000_0000;
      present_src_reg <= 1'b1;
    end
  end
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (!term_dis && strap_done_reg) state_next = ST_UNATT;
      ST_UNATT: begin
        if (acting_src && sink_seen) state_next = ST_ATT_SRC;
        else if (!acting_src && src_seen) state_next = ST_ATT_SNK;
      end
      ST_ATT_SRC: if (!sink_seen) state_next = ST_UNATT;
      ST_ATT_SNK: if (!src_seen) state_next = ST_UNATT;
      default: state_next = ST_IDLE;
    endcase
    if (term_dis)
      state_next = ST_IDLE;
  end
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      orient_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // orientation is latched on leaving unattached (attach or termination disable) and held through detach, keeping the mux still
      if (state_reg == ST_UNATT && state_next != ST_UNATT)
        orient_reg <= acting_src ? (~rd1 & rd2) : (~cc1_rp_i & cc2_rp_i);
    end
  end
  // terminations and source-only features
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rp_en_o <= 2'b00;
      rd_en_o <= 2'b00;
      rp_level_o <= `TCRC_CUR_DEF;
      vconn_en_o <= 2'b00;
      id_oe_o <= 1'b0;
      attached_src_o <= 1'b0;
      attached_snk_o <= 1'b0;
    end else begin
      attached_src_o <= (state_reg == ST_ATT_SRC);
      attached_snk_o <= (state_reg == ST_ATT_SNK);
      if (state_reg == ST_IDLE) begin
        rp_en_o <= 2'b00;
        rd_en_o <= 2'b00;
      end else if (role == `TCRC_ROLE_SRC) begin
        rp_en_o <= 2'b11;
        rd_en_o <= 2'b00;
      end else if (role == `TCRC_ROLE_SNK) begin
        rp_en_o <= 2'b00;
        rd_en_o <= 2'b11;
      end else begin
        rp_en_o <= {2{acting_src}};
        rd_en_o <= {2{~acting_src}};
      end
      // default until attached, then the higher of strap and register request
      if (state_reg != ST_ATT_SRC)
        rp_level_o <= `TCRC_CUR_DEF;
      else
        rp_level_o <= req_cur;
      id_oe_o <= (state_reg == ST_ATT_SRC) && sink_seen;
      // vconn only as source; pd messaging is absent so no cable is interrogated
      if (state_reg == ST_ATT_SRC && rd1 && cc2_ra_i)
        vconn_en_o <= VCONN_CC2;
      else if (state_reg == ST_ATT_SRC && rd2 && cc1_ra_i)
        vconn_en_o <= VCONN_CC1;
      else
        vconn_en_o <= 2'b00;
    end
  end
  // open-drain pins only pull low; the enable carries the level
  assign id_o = 1'b0;
  assign dir_o = 1'b0;
  // mux follows orientation; paths stay off while the switch settles
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mux_sel_o <= 1'b0;
      dir_oe_o <= 1'b0;
      mux_path_en_o <= 2'b00;
      sw_cnt_reg <= 8'h00;
    end else begin
      mux_sel_o <= orient_reg;
      dir_oe_o <= ~orient_reg;
      // a second flip while settling restarts the count, so paths never open mid-switch
      if (mux_sel_o != orient_reg) begin
        sw_cnt_reg <= SW_CYC8 - 8'h01;
        mux_path_en_o <= PATHS_OFF;
      end else if (sw_cnt_reg != 8'h00) begin
        sw_cnt_reg <= sw_cnt_reg - 8'h01;
      end else begin
        mux_path_en_o <= PATHS_ON;
      end
    end
  end
endmodule
`default_nettype wire

// *** tcrc_sink_model.sv ***
// partner port acting as a sink: Rd on the mated cc line, optional cable Ra on the other
// assumes the controller can sense a termination only through its own Rp on that line
`timescale 1ns/1ps
`default_nettype none
module tcrc_sink_model (
  input wire logic [1:0] rp_en_i,
  input wire logic plug_i,
  input wire logic flip_i,
  input wire logic ra_i,
  output logic [1:0] rd_o,
  output logic [1:0] ra_o
);
  // no pull-up means no voltage, so nothing is sensed while the source is off
  assign rd_o = plug_i ? (rp_en_i & (flip_i ? 2'h2 : 2'h1)) : 2'h0;
  assign ra_o = (plug_i && ra_i) ? (rp_en_i & (flip_i ? 2'h1 : 2'h2)) : 2'h0;
endmodule
`default_nettype wire

// *** test_tcrc_role_ctrl.sv ***
// self-checking bench: role straps, register role change, source attach with a sink model
// assumes attach shows within a few cycles of sensing Rd and a 16-cycle toggle half period
`timescale 1ns/1ps
`default_nettype none
module test_tcrc_role_ctrl;
  logic clk = 0, rst_b = 0, fl = 0, wr = 0, rd = 0, plug = 0, flip = 0, ra = 0;
  logic [1:0] strap = 0, cur = 0, csel = 0, rpv = 0, rp, rdn, lvl, vc, pth, rdv, rav;
  logic [7:0] addr = 0, wd = 0, rdata;
  logic id, idoe, dir, diroe, msel, asrc, asnk;
  int mismatches = 0, num_checks = 0;
  tcrc_role_ctrl #(.TOGGLE_CYCLES(16)) tcrc_role_ctrl_i (.clock_i(clk), .rst_b_i(rst_b),
    .role_strap_i(strap), .strap_float_i(fl), .current_strap_i(cur), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_cur_sel_i(csel),
    .reg_rdata_o(rdata), .cc1_rd_i(rdv[0]), .cc2_rd_i(rdv[1]), .cc1_ra_i(rav[0]),
    .cc2_ra_i(rav[1]), .cc1_rp_i(rpv[0]), .cc2_rp_i(rpv[1]), .rp_en_o(rp), .rd_en_o(rdn),
    .rp_level_o(lvl), .vconn_en_o(vc), .id_o(id), .id_oe_o(idoe), .dir_o(dir),
    .dir_oe_o(diroe), .mux_sel_o(msel), .mux_path_en_o(pth), .attached_src_o(asrc),
    .attached_snk_o(asnk));
  tcrc_sink_model tcrc_sink_model_i (.rp_en_i(rp), .plug_i(plug), .flip_i(flip),
    .ra_i(ra), .rd_o(rdv), .ra_o(rav));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic boot(input logic [1:0] s, input logic f, input logic [1:0] c);
    @(posedge clk);
    {rst_b, strap, fl, cur, plug} <= {1'b0, s, f, c, 1'b0};
    repeat (8) @(posedge clk);
    rst_b <= 1;
    step(4);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 0;
    step(1);
    chk(rdata, exp);
  endtask
  task automatic t_source(input logic f);
    boot(2'h1, 1'b0, 2'h0);
    chk({rp, rdn}, 4'hC);
    chk(lvl, 2'h0);
    @(posedge clk);
    {plug, flip, ra} <= {1'b1, f, 1'b1};
    step(6);
    chk({asrc, idoe, pth}, f ? 4'hC : 4'hF);
    chk({id, dir}, 2'h0);
    chk(vc, f ? 2'h1 : 2'h2);
    chk({msel, diroe}, {f, !f});
    step(64);
    chk(pth, 2'h3);
  endtask
  task automatic t_current();
    boot(2'h1, 1'b0, 2'h1);
    chk(lvl, 2'h0);
    @(posedge clk);
    {plug, flip, ra} <= {1'b1, 1'b0, 1'b0};
    step(4);
    chk(lvl, 2'h1);
    @(posedge clk);
    csel <= 2'h2;
    wreg(8'h0B, 8'hFF);
    rreg(8'h0A, 8'h00);
    rreg(8'h0B, 8'h00);
    chk(lvl, 2'h2);
  endtask
  task automatic t_sink();
    boot(2'h0, 1'b0, 2'h0);
    chk({rp, rdn}, 4'h3);
    @(posedge clk);
    rpv <= 2'h2;
    step(3);
    chk({asnk, msel, diroe, idoe}, 4'hC);
    chk(vc, 2'h0);
    @(posedge clk);
    rpv <= 2'h0;
    wreg(8'h0A, 8'h20);
    step(40);
    chk({rp, rdn}, 4'h3);
  endtask
  task automatic t_drp();
    logic [1:0] both;
    both = 2'h0;
    boot(2'h0, 1'b1, 2'h0);
    repeat (40) begin
      step(1);
      both = both | {rp == 2'h3, rdn == 2'h3};
    end
    chk(both, 2'h3);
    wreg(8'h0A, 8'h01);
    step(2);
    chk({rp, rdn}, 4'h0);
    wreg(8'h0A, 8'h21);
    wreg(8'h0A, 8'h20);
    rreg(8'h0A, 8'h20);
    step(40);
    chk({rp, rdn}, 4'hC);
  endtask
  initial begin
    t_source(1'b0);
    t_source(1'b1);
    t_current();
    t_sink();
    t_drp();
    print_verdict();
  end
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
